// File: src/adc_defs.svh
// Offsets, field positions, reset values and timing counts for the converter sequencer.
// Assumes a 25 MHz mclk; the times below that the logic uses are turned into whole clock cycles.
//
// What this block does
// - A conversion finishes within 385 ns fast or 520 ns normal.
// - Busy lasts at most 385/520 ns, except master read-after-convert or while a serial word is still unsent.
// - Wideband fast mode times exactly like ordinary fast mode.
// - After reset release busy stays high about 600 ns.
// - Parallel result valid within 385/520 ns of the start edge.
// - Parallel data valid at least 2 ns before busy falls.
// - Parallel bus request gets valid data within 20 ns.
// - Master read-after-convert frame sync rises about 383/500 ns after start.
// - Master read-after-convert busy falls only after frame sync falls.
// - Divider codes 00..11 start from minimum bit periods 8/16/32/64 ns, each half period rounded up to whole mclk cycles.
// - Divider codes 00..11 all give 80 ns, above the 14/26/52 ns maximum bit periods of codes 00..10.
// - Read-after-convert keeps busy through the transfer, 1.84/2.00 us fast/normal.
// - Read-during-convert bit clock period is 80 ns, two mclk cycles.
// - Chip select high releases serial data, sync and bit clock.
// - No pipeline latency: a result is readable when its conversion ends.
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and conversion from times to cycles
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     40
`define CYC_FLOOR(ns)     ((((ns) / `CLK_PERIOD_NS) < 1) ? 1 : ((ns) / `CLK_PERIOD_NS))
`define CYC_CEIL(ns)      (((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1) ? 1 : \
                            (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

// ----------------------------------------------------------------------------
// Timing figures and derived counts
// ----------------------------------------------------------------------------
`define CONV_FAST_NS      385
`define CONV_NORM_NS      520
`define SYNC_FAST_NS      383
`define SYNC_NORM_NS      500
`define RESET_BUSY_NS     600
`define DATA_LEAD_NS      2
`define CONV_FAST_CYC     `CYC_FLOOR(`CONV_FAST_NS)
`define CONV_NORM_CYC     `CYC_FLOOR(`CONV_NORM_NS)
`define RESET_BUSY_CYC    `CYC_FLOOR(`RESET_BUSY_NS)
`define DATA_LEAD_CYC     `CYC_CEIL(`DATA_LEAD_NS)
`define SCLK_MIN_NS0      8
`define SCLK_MIN_NS1      16
`define SCLK_MIN_NS2      32
`define SCLK_MIN_NS3      64
`define SCLK_MAX_NS0      14
`define SCLK_MAX_NS1      26
`define SCLK_MAX_NS2      52
`define SCLK_MAX_NS3      103
`define HALF_CYC(ns)      `CYC_CEIL((ns) / 2)

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define OFS_CTRL          8'h00
`define OFS_STATUS        8'h04
`define OFS_RESULT        8'h08
`define CTRL_FAST_BIT     0
`define CTRL_WIDE_BIT     1
`define CTRL_IF_LSB       2
`define CTRL_DIV_LSB      4
`define CTRL_WIDTH        6
`define CTRL_RESET        6'h00
`define STAT_BUSY_BIT     0
`define STAT_VALID_BIT    1
`define STAT_FULL_BIT     2
`define STAT_REFUSED_BIT  3

`endif

// File: src/adc_pkg.sv
// Types used by the converter sequencer, not by its buffer.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_pkg;
   typedef enum logic [1:0] {IF_PARALLEL, IF_MASTER_AFTER, IF_MASTER_DURING, IF_SLAVE} iface_mode_e;
   typedef enum logic [2:0] {ST_IDLE, ST_CONVERT, ST_SETTLE, ST_SHIFT, ST_DONE} conv_state_e;
endpackage

// File: src/two_entry_buffer.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer #(
   parameter int WIDTH = 18
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] entry0_reg;
   logic [WIDTH-1:0] entry1_reg;
   logic             wrPtr_reg;
   logic             rdPtr_reg;
   logic [1:0]       count_reg;
   logic             push;
   logic             pop;

   assign inReady  = (count_reg != 2'd2);
   assign outValid = (count_reg != 2'd0);
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;
   assign outData  = rdPtr_reg ? entry1_reg : entry0_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         entry0_reg <= '0;
         entry1_reg <= '0;
      end else if (push) begin
         if (wrPtr_reg) entry1_reg <= inData;
         else           entry0_reg <= inData;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= 1'b0;
         rdPtr_reg <= 1'b0;
         count_reg <= 2'd0;
      end else begin
         if (push) wrPtr_reg <= ~wrPtr_reg;
         if (pop)  rdPtr_reg <= ~rdPtr_reg;
         if (push && !pop)      count_reg <= count_reg + 2'd1;
         else if (pop && !push) count_reg <= count_reg - 2'd1;
      end
   end
endmodule // two_entry_buffer
`default_nettype wire

// File: src/adc_conv_timing.sv
// Conversion sequencer: start detection, busy timing, parallel and serial readout, APB registers.
// Assumes all pins synchronous to mclk; sampleData is the converter core's settled result.
//
// Our own choices: the APB interface to the registers and the address map.
`include "adc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module adc_conv_timing
   import adc_pkg::*;
#(
   parameter int RESULT_W = 18
) (
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic [7:0]          paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                conversion_start_n,
   input  wire logic [RESULT_W-1:0] sampleData,
   output logic                     busy,
   input  wire logic                chipSelect_n,
   input  wire logic                readEnable_n,
   output logic      [RESULT_W-1:0] parallelData,
   output logic                     parallelOe_n,
   input  wire logic                serialClockIn,
   output logic                     serialClockOut,
   output logic                     serialClockOe_n,
   output logic                     frameSync,
   output logic                     frameSyncOe_n,
   input  wire logic                serial_data_in,
   output logic                     serial_data_out,
   output logic                     serialDataOe_n
);
   localparam int BITS_W = $clog2(RESULT_W + 1);

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   logic [`CTRL_WIDTH-1:0] ctrl_reg;
   logic                   refused_reg;
   logic [31:0]            rdData_reg;
   conv_state_e            state_reg;
   logic [3:0]             convCount_reg;
   logic [4:0]             resetHold_reg;
   logic                   startPrev_reg;
   logic                   fastLatched_reg;
   logic [RESULT_W-1:0]    result_reg;
   logic                   resultValid_reg;
   logic [RESULT_W-1:0]    shift_reg;
   logic [BITS_W-1:0]      bitsLeft_reg;
   logic                   shiftLoaded_reg;
   logic                   shiftRun_reg;
   logic                   sclk_reg;
   logic                   sclkInPrev_reg;
   logic [3:0]             halfCount_reg;
   iface_mode_e            iface;
   logic                   fastMode;
   logic                   masterMode;
   logic                   serialMode;
   logic                   startEdge;
   logic                   startAccept;
   logic                   bufInValid;
   logic                   bufInReady;
   logic                   bufOutValid;
   logic                   bufOutReady;
   logic [RESULT_W-1:0]    bufOutData;
   logic                   popFire;
   logic                   halfTick;
   logic                   bitStep;
   logic [3:0]             halfCycles;
   logic                   addrHit;
   logic                   apbWrite;

   // ----------------------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------------------
   assign iface      = iface_mode_e'(ctrl_reg[`CTRL_IF_LSB +: 2]);
   assign fastMode   = ctrl_reg[`CTRL_FAST_BIT] | ctrl_reg[`CTRL_WIDE_BIT];
   assign masterMode = (iface == IF_MASTER_AFTER) || (iface == IF_MASTER_DURING);
   assign serialMode = (iface != IF_PARALLEL);

   // ----------------------------------------------------------------------------
   // Start detection
   // ----------------------------------------------------------------------------
   assign startEdge   = startPrev_reg & ~conversion_start_n;
   assign startAccept = startEdge && (state_reg == ST_IDLE) && (resetHold_reg == 5'd0) && bufInReady;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) startPrev_reg <= 1'b1;
      else        startPrev_reg <= conversion_start_n;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)                     resetHold_reg <= 5'(`RESET_BUSY_CYC);
      else if (resetHold_reg != 5'd0) resetHold_reg <= resetHold_reg - 5'd1;
   end

   // ----------------------------------------------------------------------------
   // Conversion sequence
   // ----------------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg       <= ST_IDLE;
         convCount_reg   <= 4'd0;
         fastLatched_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (startAccept) begin
                  fastLatched_reg <= fastMode;
                  // conversion length, leaving room for hand-off
                  convCount_reg   <= fastMode ? 4'(`CONV_FAST_CYC - 2 - `DATA_LEAD_CYC)
                                              : 4'(`CONV_NORM_CYC - 2 - `DATA_LEAD_CYC);
                  state_reg       <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (convCount_reg == 4'd0) begin
                  if (bufInReady) state_reg <= ST_SETTLE;
               end else begin
                  convCount_reg <= convCount_reg - 4'd1;
               end
            end
            ST_SETTLE: begin
               // result register loads a cycle before busy drops, or as the read-after-convert shift starts
               if (popFire) state_reg <= (iface == IF_MASTER_AFTER) ? ST_SHIFT : ST_DONE;
            end
            ST_SHIFT: begin
               if (!shiftLoaded_reg) state_reg <= ST_DONE;
            end
            ST_DONE:  state_reg <= ST_IDLE;
            default:  state_reg <= ST_IDLE;
         endcase
      end
   end

   assign busy       = (state_reg != ST_IDLE) || (resetHold_reg != 5'd0);
   assign bufInValid = (state_reg == ST_CONVERT) && (convCount_reg == 4'd0);

   // ----------------------------------------------------------------------------
   // Result buffer
   // ----------------------------------------------------------------------------
   // A serial word still going out stalls the buffer, so the sequence waits in ST_SETTLE with busy high and refuses starts
   assign bufOutReady = !serialMode || !shiftLoaded_reg;
   assign popFire     = bufOutValid & bufOutReady;

   two_entry_buffer #(
      .WIDTH (RESULT_W)
   ) resultBuffer (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inValid  (bufInValid),
      .inReady  (bufInReady),
      .inData   (sampleData),
      .outValid (bufOutValid),
      .outReady (bufOutReady),
      .outData  (bufOutData)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         result_reg      <= '0;
         resultValid_reg <= 1'b0;
      end else if (popFire) begin
         result_reg      <= bufOutData;
         resultValid_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------------
   // Parallel port
   // ----------------------------------------------------------------------------
   // data from the result register
   assign parallelData = result_reg;
   assign parallelOe_n = chipSelect_n | readEnable_n | (iface != IF_PARALLEL);

   // ----------------------------------------------------------------------------
   // Serial port
   // ----------------------------------------------------------------------------
   // half period per divider code
   always_comb begin
      case (ctrl_reg[`CTRL_DIV_LSB +: 2])
         2'b00:   halfCycles = 4'(`HALF_CYC(`SCLK_MIN_NS0));
         2'b01:   halfCycles = 4'(`HALF_CYC(`SCLK_MIN_NS1));
         2'b10:   halfCycles = 4'(`HALF_CYC(`SCLK_MIN_NS2));
         default: halfCycles = 4'(`HALF_CYC(`SCLK_MIN_NS3));
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)                                 halfCount_reg <= 4'd0;
      else if (!shiftRun_reg || halfCount_reg == 4'd0) halfCount_reg <= halfCycles - 4'd1;
      else                                        halfCount_reg <= halfCount_reg - 4'd1;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) sclkInPrev_reg <= 1'b0;
      else        sclkInPrev_reg <= serialClockIn;
   end

   // fastest clock the mclk allows in read-during-convert
   assign halfTick = shiftRun_reg && masterMode && (halfCount_reg == 4'd0);
   // Master shifts on its own falling edge, slave on the host's rising edge
   assign bitStep  = masterMode ? (halfTick && sclk_reg)
                                : (shiftRun_reg && !chipSelect_n && serialClockIn && !sclkInPrev_reg);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg       <= '0;
         bitsLeft_reg    <= '0;
         shiftLoaded_reg <= 1'b0;
         shiftRun_reg    <= 1'b0;
         sclk_reg        <= 1'b0;
      end else if (popFire && serialMode) begin
         shift_reg       <= bufOutData;
         bitsLeft_reg    <= BITS_W'(RESULT_W);
         shiftLoaded_reg <= 1'b1;
         // after-convert sync rises as conversion ends
         shiftRun_reg    <= (iface != IF_MASTER_DURING);
         sclk_reg        <= 1'b0;
      end else if (startAccept && shiftLoaded_reg && !shiftRun_reg) begin
         shiftRun_reg    <= 1'b1;
      end else if (shiftRun_reg) begin
         if (halfTick && !sclk_reg) sclk_reg <= 1'b1;
         if (bitStep) begin
            sclk_reg     <= 1'b0;
            shift_reg    <= {shift_reg[RESULT_W-2:0], serial_data_in};
            bitsLeft_reg <= bitsLeft_reg - BITS_W'(1);
            if (bitsLeft_reg == BITS_W'(1)) begin
               shiftRun_reg    <= 1'b0;
               shiftLoaded_reg <= 1'b0;
            end
         end
      end
   end

   // sync falls before the sequence leaves the shift state
   assign frameSync       = shiftRun_reg && masterMode;
   assign serialClockOut  = sclk_reg;
   assign serial_data_out = shift_reg[RESULT_W-1];
   assign serialClockOe_n = chipSelect_n | ~masterMode;
   assign frameSyncOe_n   = chipSelect_n | ~masterMode;
   assign serialDataOe_n  = chipSelect_n | ~serialMode;

   // ----------------------------------------------------------------------------
   // APB registers
   // ----------------------------------------------------------------------------
   assign addrHit  = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) || (paddr == `OFS_RESULT);
   assign apbWrite = psel & penable & pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~addrHit;
   assign prdata   = rdData_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)                                  ctrl_reg <= `CTRL_RESET;
      else if (apbWrite && paddr == `OFS_CTRL)     ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
   end

   // Sticky refused-start flag; a new refusal beats a clear in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)                                  refused_reg <= 1'b0;
      else if (startEdge && !startAccept)          refused_reg <= 1'b1;
      else if (apbWrite && paddr == `OFS_STATUS && pwdata[`STAT_REFUSED_BIT]) refused_reg <= 1'b0;
   end

   // Read data captured in the setup phase, held through the access phase
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_reg <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         rdData_reg <= 32'h0000_0000;
         case (paddr)
            `OFS_CTRL:   rdData_reg[`CTRL_WIDTH-1:0] <= ctrl_reg;
            `OFS_STATUS: begin
               rdData_reg[`STAT_BUSY_BIT]    <= busy;
               rdData_reg[`STAT_VALID_BIT]   <= resultValid_reg;
               rdData_reg[`STAT_FULL_BIT]    <= ~bufInReady;
               rdData_reg[`STAT_REFUSED_BIT] <= refused_reg;
            end
            `OFS_RESULT: rdData_reg[RESULT_W-1:0] <= result_reg;
            default:     rdData_reg <= 32'h0000_0000;
         endcase
      end
   end
endmodule // adc_conv_timing
`default_nettype wire

// File: sim/adc_conv_timing_properties.sv
// Port-level checker for the converter sequencer.
// Assumes CTRL changes only by APB writes at offset 0x00.
`timescale 1ns/100ps
`default_nettype none
module adc_conv_timing_properties #(
   parameter int RESULT_W = 18
) (
   input wire logic                mclk,
   input wire logic                rst_n,
   input wire logic [7:0]          paddr,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [31:0]         pwdata,
   input wire logic                conversion_start_n,
   input wire logic                busy,
   input wire logic                chipSelect_n,
   input wire logic                readEnable_n,
   input wire logic [RESULT_W-1:0] parallelData,
   input wire logic                parallelOe_n,
   input wire logic                serialClockOut,
   input wire logic                serialClockOe_n,
   input wire logic                frameSync,
   input wire logic                frameSyncOe_n,
   input wire logic                serialDataOe_n
);
   // ----
   // Shadow state
   // ----
   logic [5:0] ctrlReg;
   logic [4:0] relCnt;
   logic       sawIdle;
   logic [7:0] busyCnt;
   logic [7:0] fsCnt;
   wire logic  par = ctrlReg[3:2] == 2'h0;
   wire logic  fast = |ctrlReg[1:0];
   wire logic  after = ctrlReg[3:2] == 2'h1;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) ctrlReg <= 6'h00;
      else if (psel && penable && pwrite && paddr == 8'h00) ctrlReg <= pwdata[5:0];
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) relCnt <= 5'h00;
      else if (relCnt != 5'h1f) relCnt <= relCnt + 5'h01;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) sawIdle <= 1'b0;
      else if (!busy) sawIdle <= 1'b1;
   end
   // Run lengths
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) busyCnt <= 8'h00;
      else busyCnt <= busy ? busyCnt + 8'h01 : 8'h00;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) fsCnt <= 8'h00;
      else fsCnt <= frameSync ? fsCnt + 8'h01 : 8'h00;
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_reset_hold; relCnt < 5'h0e |-> busy; endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("busy low in reset hold");
   property p_start; par && sawIdle && !busy && $fell(conversion_start_n) |-> ##[1:2] busy; endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_fast_len; par && fast && sawIdle && $rose(busy) |-> ##8 busy ##1 !busy; endproperty
   a_fast_len: assert property (p_fast_len) else $error("fast busy length");
   property p_busy_max; par && sawIdle && busy |-> busyCnt < (fast ? 8'h09 : 8'h0d); endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy too long");
   property p_data_first; $fell(busy) |-> $stable(parallelData); endproperty
   a_data_first: assert property (p_data_first) else $error("data moved at busy fall");
   property p_par_oe; par |-> parallelOe_n == (chipSelect_n | readEnable_n); endproperty
   a_par_oe: assert property (p_par_oe) else $error("parallel drive wrong");
   property p_release; chipSelect_n |-> serialClockOe_n && frameSyncOe_n && serialDataOe_n; endproperty
   a_release: assert property (p_release) else $error("serial pins not released");
   property p_bit_clock; frameSync && serialClockOut |=> !serialClockOut; endproperty
   a_bit_clock: assert property (p_bit_clock) else $error("bit clock high too long");
   property p_sync_busy; after && $fell(frameSync) |-> busy ##[1:3] !busy; endproperty
   a_sync_busy: assert property (p_sync_busy) else $error("busy fell before sync");
   property p_frame_len; frameSync |-> fsCnt < 8'h26; endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame too long");
   c_par: cover property (par && $fell(busy));
   c_frame: cover property ($rose(frameSync));
   c_slave: cover property (ctrlReg[3:2] == 2'h3 && $fell(busy));
endmodule // adc_conv_timing_properties
bind adc_conv_timing adc_conv_timing_properties #(.RESULT_W(RESULT_W)) u_props (.mclk, .rst_n, .paddr, .psel,
   .penable, .pwrite, .pwdata, .conversion_start_n, .busy, .chipSelect_n, .readEnable_n, .parallelData,
   .parallelOe_n, .serialClockOut, .serialClockOe_n, .frameSync, .frameSyncOe_n, .serialDataOe_n);
`default_nettype wire

// File: sim/adc_host_model.sv
// Host reading a result in slave serial mode.
// Assumes a one-cycle go pulse; the bit clock stands still between frames.
`timescale 1ns/100ps
`default_nettype none
module adc_host_model (
   input wire logic   mclk,
   input wire logic   go,
   input wire logic   sdo,
   input wire logic   sdoOe_n,
   output logic        sclk,
   output logic        sdi,
   output logic [17:0] word,
   output logic        done
);
   logic lastBit;
   initial begin
      sclk = 1'b0;
      sdi = 1'b0;
      word = 18'h0_0000;
      done = 1'b0;
      lastBit = 1'b0;
      forever begin
         @(posedge mclk);
         if (go) begin
            done <= 1'b0;
            for (int i = 0; i < 18; i++) begin
               repeat (3) @(posedge mclk);
               // Released line shows no stale bit
               lastBit = sdoOe_n ? ~lastBit : sdo;
               word <= {word[16:0], lastBit};
               sclk <= 1'b1;
               sdi <= i[0];
               repeat (3) @(posedge mclk);
               sclk <= 1'b0;
            end
            done <= 1'b1;
         end
      end
   end
endmodule // adc_host_model
`default_nettype wire

// File: sim/adc_conv_timing_tb_top.sv
// Bench: APB set-up, then conversions in every readout mode.
// Assumes the host model serves slave reads on request.
`timescale 1ns/100ps
`default_nettype none
module adc_conv_timing_tb_top;
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, start_n, busy;
   logic        chipSel_n, readEn_n, parOe_n, sclkIn, sclkOut, sclkOe_n, sync, syncOe_n;
   logic        sdi, sdo, sdoOe_n, hostGo, hostDone, sclkPrev, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [17:0] sampleData, parData, hostWord, capWord, d, fallData;
   int          failures, checks, cycles, capCnt, n;
   logic [5:0]  ctrlTab [6] = '{6'h01, 6'h02, 6'h00, 6'h05, 6'h0d, 6'h09};
   int          busyTab [3] = '{9, 9, 13};
   adc_conv_timing DUT (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conversion_start_n(start_n), .sampleData(sampleData), .busy(busy), .chipSelect_n(chipSel_n),
      .readEnable_n(readEn_n), .parallelData(parData), .parallelOe_n(parOe_n), .serialClockIn(sclkIn),
      .serialClockOut(sclkOut), .serialClockOe_n(sclkOe_n), .frameSync(sync), .frameSyncOe_n(syncOe_n),
      .serial_data_in(sdi), .serial_data_out(sdo), .serialDataOe_n(sdoOe_n));
   adc_host_model u_host (.mclk(mclk), .go(hostGo), .sdo(sdo), .sdoOe_n(sdoOe_n), .sclk(sclkIn),
      .sdi(sdi), .word(hostWord), .done(hostDone));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Master bit capture on each bit clock rise
   always @(posedge mclk) begin
      sclkPrev <= sclkOut;
      if (!sclkOe_n && sclkOut && !sclkPrev) begin
         capWord <= {capWord[16:0], sdo};
         capCnt <= capCnt + 1;
      end
      cycles++;
      if (cycles == 6000) begin
         failures++;
         finish_test();
      end
   end
   // ----
   // Tasks
   // ----
   task automatic cmp_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cmp_bit(input string nm, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run_conv(input logic [5:0] ctrl, input logic [17:0] v);
      logic prevBusy;
      apb(1'b1, 8'h00, 32'(ctrl));
      sampleData <= v;
      capCnt = 0;
      n = 0;
      prevBusy = 1'b0;
      fallData = ~v;
      for (int i = 0; i < 200; i++) begin
         @(posedge mclk);
         start_n <= (i != 0 && i != 5);
         hostGo <= (i == 20 && ctrl[3:2] == 2'h3);
         #1;
         if (busy === 1'b1) n++;
         if (prevBusy && busy === 1'b0) fallData = parData;
         prevBusy = busy;
      end
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      {rst_n, psel, penable, pwrite, hostGo, chipSel_n, readEn_n} = 7'h00;
      start_n = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      sampleData = 18'h0_0000;
      {failures, checks, cycles, capCnt, n} = '0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (30) begin
         @(posedge mclk);
         #1;
         if (busy === 1'b1) n++;
      end
      cmp_bit("reset busy hold", 1'b1, n >= 14 && n <= 16);
      apb(1'b0, 8'h00, 32'h0000_0000);
      cmp_word("CTRL reset", 32'h0000_0000, rd);
      apb(1'b0, 8'h20, 32'h0000_0000);
      cmp_bit("unmapped error", 1'b1, err);
      $display("test reset done");
      for (int k = 0; k < 6; k++) begin
         readEn_n <= (ctrlTab[k][3:2] != 2'h0);
         d = 18'h2_5a5c ^ 18'(k);
         if (k == 5) run_conv(ctrlTab[k], ~d);
         run_conv(ctrlTab[k], d);
         if (k < 3) begin
            cmp_word("busy cycles", busyTab[k], n);
            cmp_word("data at busy fall", 32'(d), 32'(fallData));
            cmp_bit("parallel drive", 1'b0, parOe_n);
            apb(1'b0, 8'h08, 32'h0000_0000);
            cmp_word("RESULT", 32'(d), rd);
            apb(1'b0, 8'h04, 32'h0000_0000);
            cmp_bit("refused flag", 1'b1, rd[3]);
            apb(1'b1, 8'h04, 32'h0000_0008);
         end else begin
            cmp_word("serial word", 32'(k == 5 ? 18'(~d) : d), 32'(k == 4 ? hostWord : capWord));
            cmp_word("bit clock edges", k == 4 ? 0 : 18, capCnt);
            cmp_bit("busy after transfer", 1'b0, busy);
            if (k == 4) cmp_bit("host done", 1'b1, hostDone);
         end
         $display("test mode %0d done", k);
      end
      chipSel_n <= 1'b1;
      @(posedge mclk);
      #1;
      cmp_bit("serial release", 1'b1, sdoOe_n & sclkOe_n & syncOe_n);
      finish_test();
   end
endmodule // adc_conv_timing_tb_top
`default_nettype wire
